// ---- verilog/ips_pkg.sv ----
// Purpose: shared constants and types of the paged control-port slave
// Assumes: 10 MHz core clock, 8-bit registers, 128 locations per page
// Notes:   all register defaults are zero unless changed here
package ips_pkg;

  // ==========================================================
  // clock
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 100;

  // ==========================================================
  // slave address
  // ==========================================================
  localparam logic [4:0] SLV_ADDR_HI = 5'h13;
  localparam logic [6:0] BCAST_ADDR  = 7'h4C;

  // ==========================================================
  // register map, page geometry and fields
  // ==========================================================
  localparam int unsigned PAGE_SIZE = 128;
  localparam logic [6:0]  REG_PAGE  = 7'h00;
  localparam logic [6:0]  REG_SRST  = 7'h01;
  localparam logic [6:0]  REG_SLEEP = 7'h02;
  localparam int unsigned SRST_BIT  = 0;
  localparam int unsigned BCAST_BIT = 2;
  localparam logic [7:0]  PAGE_CFG  = 8'h00;
  localparam logic [7:0]  PAGE_CO0  = 8'h02;
  localparam logic [7:0]  PAGE_CO1  = 8'h03;
  localparam logic [7:0]  PAGE_CO2  = 8'h04;
  localparam int unsigned NUM_PAGES = 4;
  localparam logic [7:0]  PAGE_RST  = 8'h00;
  localparam logic [7:0]  REG_RST   = 8'h00;
  // idle pin levels {sda, scl, a0, a1}: bus lines high, straps low
  localparam logic [3:0]  PINS_IDLE = 4'hC;

  // ==========================================================
  // types
  // ==========================================================
  typedef struct packed {
    logic sda;
    logic scl;
    logic a0;
    logic a1;
  } ips_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK  = 3'h3,
    ST_RX   = 3'h2,
    ST_TX   = 3'h6,
    ST_MACK = 3'h7
  } ips_state_e;

endpackage

// ---- verilog/ips_sync.sv ----
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: inputs are levels, not pulses shorter than two clocks
// Notes:   the first stage feeds only the second; both reset to RST_VAL
`timescale 1ns/100ps
module ips_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ---- verilog/ips_i2c_slave.sv ----
// Purpose: paged 8-bit register bank reached by an I2C slave port
// Assumes: 10 MHz clock, bus pins are asynchronous and pass a synchroniser
// Notes:   SPI framing is not decoded; SPI use only parks the I2C engine
// Functional notes
// - soft reset bit may be written any time and always reads back zero
// - soft reset clears every register and coefficient to its default
// - every register is eight bits wide, grouped into pages
// - each page holds 128 locations addressed within the current page
// - configuration lives in page 0, selected after reset and soft reset
// - coefficient registers live in pages two, three and four
// - location zero of every page holds the page number, write selects it
// - protocol detected from pin activity without any setting
// - works at standard, fast and fast-plus bus rates
// - slave address upper five bits fixed at 10011
// - without broadcast, low address bits come from the strap pins
// - broadcast enable forces slave address 1001100
// - bytes travel MSB first, each byte acknowledged by the receiver
// - start is data falling with clock high, stop is data rising
// - slave acknowledges by holding data low for the whole ack clock
// - any number of bytes accepted between start and stop
// - first write byte sets register, later bytes go to next registers
// - slave acks own write address, the register byte and each data byte
// - read returns chosen register then following ones while master acks
// - page write works from any page, later accesses use that page
`timescale 1ns/100ps
module ips_i2c_slave (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       data_or_select_pin_i,
  output logic            data_or_select_pin_o,
  output logic            data_or_select_pin_oe_o,
  input  wire logic       scl_or_mosi_pin_i,
  input  wire logic       addr_lsb_or_serial_clock_pin_i,
  input  wire logic       addr_bit1_or_serial_out_pin_i,
  output logic [7:0]      page_o,
  output logic            broadcast_address_enable_o,
  output logic            soft_reset_bit_o,
  output logic            i2c_mode_o,
  output logic            spi_mode_o
);

  // ==========================================================
  // pin synchronisation and bus events
  // ==========================================================
  ips_pkg::ips_pins_s pins_raw;
  ips_pkg::ips_pins_s pins;
  ips_pkg::ips_pins_s pins_q;

  assign pins_raw.sda = data_or_select_pin_i;
  assign pins_raw.scl = scl_or_mosi_pin_i;
  assign pins_raw.a0  = addr_lsb_or_serial_clock_pin_i;
  assign pins_raw.a1  = addr_bit1_or_serial_out_pin_i;

  ips_sync #(
    .WIDTH   (4),
    .RST_VAL (ips_pkg::PINS_IDLE)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (pins_raw),
    .q_o    (pins)
  );

  // idle bus levels so that release from reset makes no false edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_q <= ips_pkg::PINS_IDLE;
    end else begin
      pins_q <= pins;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic a0_edge;

  assign scl_rise  = pins.scl & ~pins_q.scl;
  assign scl_fall  = ~pins.scl & pins_q.scl;
  assign bus_start = pins.scl & pins_q.scl & pins_q.sda & ~pins.sda;
  assign bus_stop  = pins.scl & pins_q.scl & ~pins_q.sda & pins.sda;
  assign a0_edge   = pins.a0 ^ pins_q.a0;

  // ==========================================================
  // register storage
  // ==========================================================
  localparam int unsigned MEM_WORDS = ips_pkg::NUM_PAGES
                                      * ips_pkg::PAGE_SIZE;

  logic [7:0] mem [0:MEM_WORDS-1];
  logic [7:0] page;
  logic [7:0] next_page;
  logic       srst;
  logic       next_srst;
  logic       mem_we;
  logic [8:0] mem_addr;
  logic [7:0] mem_wd;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;
  logic       bcast_en;

  // maps a page number onto its storage slot; reserved pages hold nothing
  function automatic logic [2:0] page_slot(input logic [7:0] p);
    logic [2:0] s;
    s = 3'h0;
    if (p == ips_pkg::PAGE_CFG) begin
      s = 3'h4;
    end else if (p == ips_pkg::PAGE_CO0) begin
      s = 3'h5;
    end else if (p == ips_pkg::PAGE_CO1) begin
      s = 3'h6;
    end else if (p == ips_pkg::PAGE_CO2) begin
      s = 3'h7;
    end
    return s;
  endfunction

  logic [2:0] slot;
  assign slot = page_slot(page);

  assign bcast_en = mem[{2'h0, ips_pkg::REG_SLEEP}][ips_pkg::BCAST_BIT];

  // ==========================================================
  // protocol detection
  // ==========================================================
  logic i2c_seen;
  logic spi_seen;
  logic next_i2c_seen;
  logic next_spi_seen;
  logic addr_hit;

  // straps never toggle under I2C, so a serial clock edge while the
  // select line is low means SPI, unless an I2C address already matched
  always_comb begin
    next_i2c_seen = i2c_seen | addr_hit;
    next_spi_seen = spi_seen
                    | (~i2c_seen & ~addr_hit
                       & a0_edge & ~pins.sda);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      i2c_seen <= 1'b0;
      spi_seen <= 1'b0;
    end else begin
      i2c_seen <= next_i2c_seen;
      spi_seen <= next_spi_seen;
    end
  end

  // ==========================================================
  // I2C engine
  // ==========================================================
  ips_pkg::ips_state_e state;
  ips_pkg::ips_state_e next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic       done;
  logic       next_done;
  logic       rw;
  logic       next_rw;
  logic [6:0] ptr;
  logic [6:0] next_ptr;
  logic       regpend;
  logic       next_regpend;
  logic       drive;
  logic       next_drive;
  logic [6:0] my_addr;

  assign my_addr = bcast_en ? ips_pkg::BCAST_ADDR
                            : {ips_pkg::SLV_ADDR_HI,
                               pins.a1, pins.a0};

  assign rd_addr = {slot[1:0], ptr};
  assign rd_data = (ptr == ips_pkg::REG_PAGE) ? page
                 : slot[2] ? mem[rd_addr] : 8'h00;

  always_comb begin
    logic load;
    load         = 1'b0;
    next_state   = state;
    next_cnt     = cnt;
    next_shift   = shift;
    next_done    = done;
    next_rw      = rw;
    next_ptr     = ptr;
    next_regpend = regpend;
    next_drive   = drive;
    next_page    = page;
    next_srst    = 1'b0;
    mem_we       = 1'b0;
    mem_addr     = {slot[1:0], ptr};
    mem_wd       = shift;
    addr_hit     = 1'b0;
    if (spi_seen) begin
      next_state = ips_pkg::ST_IDLE;
      next_drive = 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the register pointer for the read phase
      next_state = ips_pkg::ST_ADDR;
      next_cnt   = 3'h0;
      next_done  = 1'b0;
      next_drive = 1'b0;
    end else if (bus_stop) begin
      next_state = ips_pkg::ST_IDLE;
      next_drive = 1'b0;
    end else begin
      case (state)
        ips_pkg::ST_ADDR, ips_pkg::ST_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], pins.sda};
            next_cnt   = cnt + 3'h1;
            if (cnt == 3'h7) begin
              next_done = 1'b1;
            end
          end else if (scl_fall && done) begin
            next_done = 1'b0;
            if (state == ips_pkg::ST_ADDR) begin
              if (shift[7:1] == my_addr) begin
                addr_hit     = 1'b1;
                next_rw      = shift[0];
                next_regpend = ~shift[0];
                next_state   = ips_pkg::ST_ACK;
                next_drive   = 1'b1;
              end else begin
                next_state = ips_pkg::ST_IDLE;
              end
            end else begin
              if (regpend) begin
                next_ptr     = shift[6:0];
                next_regpend = 1'b0;
              end else begin
                next_ptr = ptr + 7'h1;
                if (ptr == ips_pkg::REG_PAGE) begin
                  next_page = shift;
                end else if (slot == 3'h4
                             && ptr == ips_pkg::REG_SRST) begin
                  next_srst = shift[ips_pkg::SRST_BIT];
                end else if (slot[2]) begin
                  mem_we = 1'b1;
                end
              end
              next_state = ips_pkg::ST_ACK;
              next_drive = 1'b1;
            end
          end
        end
        ips_pkg::ST_ACK: begin
          // held low from the fall after bit 8 to the fall after the ack
          if (scl_fall) begin
            next_cnt = 3'h0;
            if (rw) begin
              load = 1'b1;
            end else begin
              next_drive = 1'b0;
              next_state = ips_pkg::ST_RX;
            end
          end
        end
        ips_pkg::ST_TX: begin
          if (scl_fall) begin
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h7) begin
              next_drive = 1'b0;
              next_state = ips_pkg::ST_MACK;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_drive = ~shift[6];
            end
          end
        end
        ips_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (pins.sda) begin
              next_state = ips_pkg::ST_IDLE;
            end else begin
              next_done = 1'b1;
            end
          end else if (scl_fall && done) begin
            next_done = 1'b0;
            load      = 1'b1;
          end
        end
        default: begin
          next_drive = 1'b0;
        end
      endcase
    end
    if (load) begin
      next_shift = rd_data;
      next_ptr   = ptr + 7'h1;
      next_cnt   = 3'h0;
      next_drive = ~rd_data[7];
      next_state = ips_pkg::ST_TX;
    end
    if (srst) begin
      next_page = ips_pkg::PAGE_RST;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state   <= ips_pkg::ST_IDLE;
      cnt     <= 3'h0;
      shift   <= 8'h00;
      done    <= 1'b0;
      rw      <= 1'b0;
      ptr     <= 7'h00;
      regpend <= 1'b0;
      drive   <= 1'b0;
      page    <= ips_pkg::PAGE_RST;
      srst    <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      shift   <= next_shift;
      done    <= next_done;
      rw      <= next_rw;
      ptr     <= next_ptr;
      regpend <= next_regpend;
      drive   <= next_drive;
      page    <= next_page;
      srst    <= next_srst;
    end
  end

  // ==========================================================
  // storage update
  // ==========================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= ips_pkg::REG_RST;
      end
    end else if (srst) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= ips_pkg::REG_RST;
      end
    end else if (mem_we) begin
      mem[mem_addr] <= mem_wd;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // open-drain: value is always low, only the enable moves
  assign data_or_select_pin_o       = 1'b0;
  assign data_or_select_pin_oe_o    = drive;
  assign page_o                     = page;
  assign broadcast_address_enable_o = bcast_en;
  assign soft_reset_bit_o           = srst;
  assign i2c_mode_o                 = i2c_seen;
  assign spi_mode_o                 = spi_seen;

endmodule

// ---- sim/ips_host_model.sv ----
// Purpose: I2C bus master standing in for the host processor
// Assumes: open-drain bus with pull-up; lines move at falling clk
// Notes:   quarter bit time is q core clocks, Q unless the bench sets q
`timescale 1ns/100ps
module ips_host_model #(
  parameter int Q = 10
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  int q = Q;

  // ==========================================================
  // bus phases
  // ==========================================================
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // start or repeated start; besides I2C phases this host only parks the select line in sel_c
  task automatic start_c();
    sda_o = 1'b1;
    tk(q);
    scl_o = 1'b1;
    tk(q);
    sda_o = 1'b0;
    tk(q);
    scl_o = 1'b0;
    tk(q);
  endtask

  task automatic stop_c();
    sda_o = 1'b0;
    tk(q);
    scl_o = 1'b1;
    tk(q);
    sda_o = 1'b1;
    tk(q);
  endtask

  // parks the shared select line at a level, as an SPI host would
  task automatic sel_c(input logic v);
    sda_o = v;
    tk(q);
  endtask

  // data moves only while clock is low, sampled mid high phase
  task automatic bit_c(input logic b, output logic s);
    sda_o = b;
    tk(q);
    scl_o = 1'b1;
    tk(q);
    s = sda_i;
    tk(q);
    scl_o = 1'b0;
    tk(q);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, b[i]);
    bit_c(nack, s);
  endtask
endmodule

// ---- sim/ips_i2c_slave_assertions.sv ----
// Purpose: port-level checks of the I2C register slave
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every ips_i2c_slave instance
`timescale 1ns/100ps
module ips_i2c_slave_chk (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       data_or_select_pin_i,
  input wire logic       data_or_select_pin_o,
  input wire logic       data_or_select_pin_oe_o,
  input wire logic       scl_or_mosi_pin_i,
  input wire logic       addr_lsb_or_serial_clock_pin_i,
  input wire logic       addr_bit1_or_serial_out_pin_i,
  input wire logic [7:0] page_o,
  input wire logic       broadcast_address_enable_o,
  input wire logic       soft_reset_bit_o,
  input wire logic       i2c_mode_o,
  input wire logic       spi_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_pulse_end;
    soft_reset_bit_o ##1 !soft_reset_bit_o;
  endsequence
  sequence s_cleared;
    page_o == 8'h00 ##0 !broadcast_address_enable_o;
  endsequence

  chk_open_drain: assert property (data_or_select_pin_o == 1'b0)
    else $error("data pin driven high");
  chk_srst_clears: assert property (s_pulse_end |-> s_cleared)
    else $error("soft reset left state");
  chk_srst_self: assert property (soft_reset_bit_o |=> !soft_reset_bit_o)
    else $error("soft reset not self clearing");
  chk_rst_page: assert property ($rose(rstn_i) |-> page_o == 8'h00)
    else $error("page not zero after reset");
  chk_ack_scl_low: assert property (
    $rose(data_or_select_pin_oe_o) |-> !scl_or_mosi_pin_i)
    else $error("data pulled while clock high");
  chk_rel_scl_low: assert property (
    $fell(data_or_select_pin_oe_o) |-> !scl_or_mosi_pin_i)
    else $error("data released while clock high");
  chk_mode_excl: assert property (!(i2c_mode_o && spi_mode_o))
    else $error("both protocols flagged");
  chk_spi_quiet: assert property (
    spi_mode_o |-> !data_or_select_pin_oe_o)
    else $error("pin driven in spi mode");
  chk_page_at_ack: assert property (
    $changed(page_o) |-> ##[0:2] data_or_select_pin_oe_o)
    else $error("page changed outside ack");
  chk_bcast_at_ack: assert property (
    $changed(broadcast_address_enable_o) |-> ##[0:2] data_or_select_pin_oe_o)
    else $error("broadcast changed outside ack");
endmodule

bind ips_i2c_slave ips_i2c_slave_chk i_chk (
  .clk_i(clk_i), .rstn_i(rstn_i),
  .data_or_select_pin_i(data_or_select_pin_i),
  .data_or_select_pin_o(data_or_select_pin_o),
  .data_or_select_pin_oe_o(data_or_select_pin_oe_o),
  .scl_or_mosi_pin_i(scl_or_mosi_pin_i),
  .addr_lsb_or_serial_clock_pin_i(addr_lsb_or_serial_clock_pin_i),
  .addr_bit1_or_serial_out_pin_i(addr_bit1_or_serial_out_pin_i),
  .page_o(page_o), .soft_reset_bit_o(soft_reset_bit_o),
  .broadcast_address_enable_o(broadcast_address_enable_o),
  .i2c_mode_o(i2c_mode_o), .spi_mode_o(spi_mode_o)
);

// ---- sim/ips_i2c_slave_test.sv ----
// Purpose: self-checking bench of the paged I2C register slave
// Assumes: 10 MHz core clock, bus bit time of four host quarter periods
// Notes:   expected bytes follow the register defaults of zero
`timescale 1ns/100ps
module ips_i2c_slave_test;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       a0 = 1'b0;
  logic       a1 = 1'b0;
  logic       scl, h_sda, oe, dout, bc, srst, im, sm;
  logic [7:0] page;
  int         err_total = 0;
  int         total_checks = 0;
  wire        sda = h_sda & (oe ? dout : 1'b1);

  always #50 clk = ~clk;

  ips_i2c_slave i_dut (
    .clk_i(clk), .rstn_i(rstn),
    .data_or_select_pin_i(sda), .data_or_select_pin_o(dout),
    .data_or_select_pin_oe_o(oe), .scl_or_mosi_pin_i(scl),
    .addr_lsb_or_serial_clock_pin_i(a0),
    .addr_bit1_or_serial_out_pin_i(a1),
    .page_o(page), .broadcast_address_enable_o(bc),
    .soft_reset_bit_o(srst), .i2c_mode_o(im), .spi_mode_o(sm)
  );
  ips_host_model i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_o(h_sda));

  // ==========================================================
  // compare and bus tasks
  // ==========================================================
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic probe(input logic [6:0] dev, input logic exp);
    logic ack;
    i_host.start_c();
    i_host.put_byte({dev, 1'b0}, ack);
    i_host.stop_c();
    chk_bit(ack, exp);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] rg,
                    input logic [7:0] d [4], input int n);
    logic ack;
    i_host.start_c();
    i_host.put_byte({dev, 1'b0}, ack);
    chk_bit(ack, 1'b1);
    i_host.put_byte(rg, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_host.put_byte(d[i], ack);
      chk_bit(ack, 1'b1);
    end
    i_host.stop_c();
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] rg,
                    input logic [7:0] e [4], input int n);
    logic       ack;
    logic [7:0] b;
    i_host.start_c();
    i_host.put_byte({dev, 1'b0}, ack);
    i_host.put_byte(rg, ack);
    i_host.start_c();
    i_host.put_byte({dev, 1'b1}, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_host.get_byte(i == n - 1, b);
      chk_byte(b, e[i]);
    end
    i_host.stop_c();
  endtask

  task automatic final_report();
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk_byte(page, 8'h00);
    chk_bit(bc, 1'b0);
    for (int s = 0; s < 4; s++) begin
      {a1, a0} = s[1:0];
      repeat (4) @(negedge clk);
      for (int d = 0; d < 4; d++)
        probe({5'h13, d[1:0]}, d == s);
      probe(7'h2C, 1'b0);
    end
    chk_bit(im, 1'b1);
    chk_bit(sm, 1'b0);
    {a1, a0} = 2'b10;
    repeat (4) @(negedge clk);
    wr(7'h4E, 8'h02, '{8'h04, 8'h11, 8'h22, 8'h00}, 3);
    chk_bit(bc, 1'b1);
    probe(7'h4E, 1'b0);
    rd(7'h4C, 8'h02, '{8'h04, 8'h11, 8'h22, 8'h00}, 3);
    for (int p = 2; p < 5; p++) begin
      wr(7'h4C, 8'h00, '{p[7:0], 8'h00, 8'h00, 8'h00}, 1);
      chk_byte(page, p[7:0]);
      wr(7'h4C, 8'h7F, '{8'hA5, p[7:0], 8'h5A, 8'h00}, 3);
      rd(7'h4C, 8'h7F, '{8'hA5, p[7:0], 8'h5A, 8'h00}, 3);
    end
    wr(7'h4C, 8'h00, '{8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk_byte(page, 8'h00);
    rd(7'h4C, 8'h7F, '{8'h00, 8'h00, 8'h00, 8'h00}, 1);
    wr(7'h4C, 8'h01, '{8'h01, 8'h00, 8'h00, 8'h00}, 1);
    chk_bit(bc, 1'b0);
    chk_byte(page, 8'h00);
    probe(7'h4E, 1'b1);
    rd(7'h4E, 8'h01, '{8'h00, 8'h00, 8'h00, 8'h00}, 3);
    wr(7'h4E, 8'h00, '{8'h03, 8'h00, 8'h00, 8'h00}, 1);
    rd(7'h4E, 8'h7F, '{8'h00, 8'h03, 8'h00, 8'h00}, 3);
    // slow standard rate first, then a fast-plus rate of three core clocks per quarter bit
    for (int k = 0; k < 2; k++) begin
      i_host.q = (k == 0) ? 25 : 3;
      wr(7'h4E, 8'h10, '{8'h3C ^ k[7:0], 8'hC3 ^ k[7:0], 8'h00, 8'h00},
         2);
      rd(7'h4E, 8'h10, '{8'h3C ^ k[7:0], 8'hC3 ^ k[7:0], 8'h00, 8'h00},
         2);
    end
    // fresh reset, then an SPI-looking host: the I2C engine must stay mute
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk_byte(page, 8'h00);
    chk_bit(im, 1'b0);
    i_host.sel_c(1'b0);
    repeat (2) begin
      a0 = ~a0;
      repeat (4) @(negedge clk);
    end
    i_host.sel_c(1'b1);
    chk_bit(sm, 1'b1);
    chk_bit(im, 1'b0);
    probe(7'h4E, 1'b0);
    final_report();
  end

  initial begin
    #8_000_000;
    err_total++;
    final_report();
  end
endmodule
